// ---- rtl/bldc_ctrl_consts.vh ----
`ifndef BLDC_CTRL_CONSTS_VH
`define BLDC_CTRL_CONSTS_VH
// Clock and timing
`define CLK_FREQ_HZ          40000000
`define TACH_PULSE_NS        113000
`define TACH_PULSE_CYC       ((`TACH_PULSE_NS * 40) / 1000)
`define POWERUP_BRAKE_NS     200000
`define POWERUP_BRAKE_CYC    ((`POWERUP_BRAKE_NS * 40) / 1000)
`define CHOP_FREQ_HZ         14800
`define CHOP_DIV_CYC         (`CLK_FREQ_HZ / `CHOP_FREQ_HZ)
// APB register byte offsets
`define REG_CTRL             12'h000
`define REG_STATUS           12'h004
`define REG_IRQ_STAT         12'h008
`define REG_IRQ_MASK         12'h00c
`define REG_HALL             12'h010
// Control register fields
`define CTRL_SW_COAST        0
`define CTRL_SW_BRAKE        1
`define CTRL_RESET_VAL       32'h0000_0000
// Interrupt event bits
`define IRQ_COMMUTATE        0
`define IRQ_OVERCURRENT      1
`define IRQ_UNDERVOLT        2
`define IRQ_DIR_CHANGE       3
`define IRQ_ILLEGAL_HALL     4
`define IRQ_WIDTH            5
`endif

// ---- rtl/sync2.v ----
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter W = 1
) (
   input  wire         ref_clk_i,
   input  wire         reset_n_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule // sync2
`default_nettype wire

// ---- rtl/bldc_commutation_protection_logic.v ----
// Behaviour
// RULE1 - Any hall input change emits one tach pulse of fixed 113 us width.
// RULE2 - Hall latches stay frozen while the tach pulse is high.
// RULE3 - Brake input below threshold: all high sides off, all low sides on.
// RULE4 - Coast input above threshold: every phase goes high impedance.
// RULE5 - Undervoltage or overcurrent sets soft-start latch, discharging cap.
// RULE6 - Latch clears only with cap below restart level and no fault.
// RULE7 - Direction latch follows input at low speed, holds at high speed.
// RULE8 - Latched direction passes two chop-clocked shift stages to decoder.
// RULE9 - Any latch or stage input/output mismatch forces all phases Hi-Z.
// RULE10 - Reversal inserts one to two chop cycles of dead-time.
// RULE11 - Each phase sources, sinks or floats per hall and direction.
// RULE12 - 60 degree sensor motors need one or two halls inverted outside.
// RULE13 - Host should feed filtered tach to speed input for slow reversal.
// RULE14 - Quad low chops low sides only; high chops all six; not in brake.
// RULE15 - PWM comparator trip clears PWM latch, chopping off till cycle end.
// RULE16 - Overcurrent keeps phases off and soft-start active until removed.
// RULE17 - At power-up hold brake mode about 200 us for bootstrap charge.
// RULE18 - Illegal hall codes 000 and 111 turn every phase off.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bldc_ctrl_consts.vh"
module bldc_commutation_protection_logic #(
   parameter TACH_CYC    = `TACH_PULSE_CYC,
   parameter PWRUP_CYC   = `POWERUP_BRAKE_CYC,
   parameter CHOP_DIV    = `CHOP_DIV_CYC
) (
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   input  wire        hall_sensor_one_i,
   input  wire        hall_sensor_two_i,
   input  wire        hall_sensor_three_i,
   input  wire        direction_i,
   input  wire        speed_above_thr_i,
   input  wire        brake_below_thr_i,
   input  wire        overvoltage_freewheel_input_i,
   input  wire        quad_select_i,
   input  wire        pwm_trip_i,
   input  wire        overcurrent_i,
   input  wire        undervoltage_i,
   input  wire        softstart_below_restart_i,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg         tach_o,
   output reg  [2:0]  high_side_on_o,
   output reg  [2:0]  low_side_on_o,
   output reg         softstart_discharge_o,
   output wire        irq_o
);
   // Sync every pin-level input
   wire [13:0] raw_in = {hall_sensor_one_i, hall_sensor_two_i,
                         hall_sensor_three_i, direction_i,
                         speed_above_thr_i, brake_below_thr_i,
                         overvoltage_freewheel_input_i, quad_select_i,
                         pwm_trip_i, overcurrent_i, undervoltage_i,
                         softstart_below_restart_i, 1'b0, 1'b0};
   wire [13:0] s_in;

   sync2 #(.W(14)) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .d_i       (raw_in),
      .q_o       (s_in)
   );

   wire [2:0] hall_s     = s_in[13:11];
   wire       dir_s      = s_in[10];
   wire       speed_hi   = s_in[9];
   wire       brake_s    = s_in[8];
   wire       coast_s    = s_in[7];
   wire       quad_s     = s_in[6];
   wire       pwm_trip_s = s_in[5];
   wire       oc_s       = s_in[4];
   wire       uv_s       = s_in[3];
   wire       ss_low_s   = s_in[2];

   // Chop oscillator enable
   reg [15:0] chop_cnt_ff;
   wire       chop_tick = (chop_cnt_ff == 16'h0000);

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         chop_cnt_ff <= 16'h0000;
      else if (chop_tick)
         chop_cnt_ff <= CHOP_DIV[15:0] - 16'h0001;
      else
         chop_cnt_ff <= chop_cnt_ff - 16'h0001;
   end

   // Hall latch and tach one-shot
   reg [2:0]  hall_ff;
   reg [15:0] tach_cnt_ff;
   wire       hall_chg = (hall_s != hall_ff) && !tach_o;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hall_ff     <= 3'h0;
         tach_o      <= 1'b0;
         tach_cnt_ff <= 16'h0000;
      end else if (hall_chg) begin
         hall_ff     <= hall_s; // RULE2
         tach_o      <= 1'b1; // RULE1
         tach_cnt_ff <= TACH_CYC[15:0] - 16'h0001;
      end else if (tach_o) begin
         if (tach_cnt_ff == 16'h0000)
            tach_o <= 1'b0; // RULE1
         else
            tach_cnt_ff <= tach_cnt_ff - 16'h0001;
      end
   end

   // Direction latch and two-stage shift register
   reg dir_latch_ff;
   reg dir_sr1_ff;
   reg dir_sr2_ff;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dir_latch_ff <= 1'b0;
         dir_sr1_ff   <= 1'b0;
         dir_sr2_ff   <= 1'b0;
      end else begin
         if (!speed_hi)
            dir_latch_ff <= dir_s; // RULE7
         if (chop_tick) begin
            dir_sr1_ff <= dir_latch_ff; // RULE8 RULE10
            dir_sr2_ff <= dir_sr1_ff;
         end
      end
   end

   // Latch is transparent at low speed, so its input is the pin then
   wire dir_lat_in = speed_hi ? dir_latch_ff : dir_s;
   wire dir_mismatch = (dir_lat_in != dir_latch_ff) ||
                       (dir_latch_ff != dir_sr1_ff) ||
                       (dir_sr1_ff != dir_sr2_ff); // RULE9

   // Soft-start latch
   reg ss_latch_ff;
   wire fault = oc_s || uv_s;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         ss_latch_ff <= 1'b1;
      else if (fault)
         ss_latch_ff <= 1'b1; // RULE5 RULE16
      else if (ss_latch_ff && ss_low_s)
         ss_latch_ff <= 1'b0; // RULE6
   end

   // PWM latch: set each chop cycle, cleared by a comparator trip
   reg pwm_on_ff;

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         pwm_on_ff <= 1'b0;
      else if (pwm_trip_s)
         pwm_on_ff <= 1'b0; // RULE15
      else if (chop_tick)
         pwm_on_ff <= 1'b1;
   end

   // Power-up brake hold
   reg [15:0] pwrup_cnt_ff;
   wire       pwrup_brake = (pwrup_cnt_ff != 16'h0000);

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         pwrup_cnt_ff <= PWRUP_CYC[15:0]; // RULE17
      else if (pwrup_brake)
         pwrup_cnt_ff <= pwrup_cnt_ff - 16'h0001;
   end

   // Registers
   reg [1:0]           ctrl_ff;
   reg [`IRQ_WIDTH-1:0] irq_stat_ff;
   reg [`IRQ_WIDTH-1:0] irq_mask_ff;
   reg                 dir_prev_ff;
   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && !pwrite;
   wire addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                  (paddr == `REG_IRQ_STAT) || (paddr == `REG_IRQ_MASK) ||
                  (paddr == `REG_HALL);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Judged on the incoming code, so entering an illegal state is flagged
   wire illegal_hall = (hall_s == 3'b000) || (hall_s == 3'b111);
   wire [`IRQ_WIDTH-1:0] irq_evt = {illegal_hall && hall_chg,
                                    dir_prev_ff != dir_sr2_ff,
                                    uv_s, oc_s, hall_chg};

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_ff     <= 2'b00;
         irq_stat_ff <= {`IRQ_WIDTH{1'b0}};
         irq_mask_ff <= {`IRQ_WIDTH{1'b0}};
         dir_prev_ff <= 1'b0;
      end else begin
         dir_prev_ff <= dir_sr2_ff;
         if (wr_en && paddr == `REG_CTRL)
            ctrl_ff <= pwdata[1:0];
         if (wr_en && paddr == `REG_IRQ_MASK)
            irq_mask_ff <= pwdata[`IRQ_WIDTH-1:0];
         // Set wins over a write-one clear in the same cycle
         if (wr_en && paddr == `REG_IRQ_STAT)
            irq_stat_ff <= (irq_stat_ff & ~pwdata[`IRQ_WIDTH-1:0]) | irq_evt;
         else
            irq_stat_ff <= irq_stat_ff | irq_evt;
      end
   end

   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         prdata <= 32'h0000_0000;
      else if (rd_en && !penable) begin
         case (paddr)
            `REG_CTRL:     prdata <= {30'h0, ctrl_ff};
            `REG_STATUS:   prdata <= {24'h0, pwm_on_ff, pwrup_brake,
                                      dir_mismatch, ss_latch_ff,
                                      dir_sr2_ff, dir_sr1_ff,
                                      dir_latch_ff, tach_o};
            `REG_IRQ_STAT: prdata <= {27'h0, irq_stat_ff};
            `REG_IRQ_MASK: prdata <= {27'h0, irq_mask_ff};
            `REG_HALL:     prdata <= {29'h0, hall_ff};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Commutation decode: per phase {src, snk}
   reg [5:0] pat;

   always @* begin
      case ({dir_sr2_ff, hall_ff}) // RULE11
         4'b1001: pat = 6'b00_01_10;
         4'b1011: pat = 6'b01_00_10;
         4'b1010: pat = 6'b01_10_00;
         4'b1110: pat = 6'b00_10_01;
         4'b1100: pat = 6'b10_00_01;
         4'b1101: pat = 6'b10_01_00;
         4'b0101: pat = 6'b01_10_00;
         4'b0100: pat = 6'b01_00_10;
         4'b0110: pat = 6'b00_01_10;
         4'b0010: pat = 6'b10_01_00;
         4'b0011: pat = 6'b10_00_01;
         4'b0001: pat = 6'b00_10_01;
         default: pat = 6'b00_00_00; // RULE18
      endcase
   end

   wire [2:0] src = {pat[5], pat[3], pat[1]};
   wire [2:0] snk = {pat[4], pat[2], pat[0]};
   wire chop_ok = pwm_on_ff;
   wire sw_coast = ctrl_ff[`CTRL_SW_COAST];
   wire sw_brake = ctrl_ff[`CTRL_SW_BRAKE];

   reg [2:0] nxt_hs;
   reg [2:0] nxt_ls;

   always @* begin
      if (coast_s || sw_coast || dir_mismatch || ss_latch_ff) begin
         nxt_hs = 3'b000; // RULE4 RULE9 RULE16
         nxt_ls = 3'b000;
      end else if (brake_s || sw_brake || pwrup_brake) begin
         nxt_hs = 3'b000; // RULE3 RULE17 RULE14
         nxt_ls = 3'b111;
      end else begin
         nxt_hs = quad_s ? (src & {3{chop_ok}}) : src; // RULE14 RULE15
         nxt_ls = snk & {3{chop_ok}};
      end
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         high_side_on_o        <= 3'b000;
         low_side_on_o         <= 3'b000;
         softstart_discharge_o <= 1'b1;
      end else begin
         high_side_on_o        <= nxt_hs;
         low_side_on_o         <= nxt_ls & ~nxt_hs;
         softstart_discharge_o <= ss_latch_ff; // RULE5
      end
   end
endmodule // bldc_commutation_protection_logic
`default_nettype wire

// ---- dv/bldc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module bldc_checker #(
   parameter TACH_CYC  = 20,
   parameter PWRUP_CYC = 30
) (
   input wire       ref_clk_i,
   input wire       reset_n_i,
   input wire       direction_i,
   input wire       speed_above_thr_i,
   input wire       brake_below_thr_i,
   input wire       overvoltage_freewheel_input_i,
   input wire       overcurrent_i,
   input wire       softstart_below_restart_i,
   input wire       tach_o,
   input wire [2:0] high_side_on_o,
   input wire [2:0] low_side_on_o,
   input wire       softstart_discharge_o
);
   reg  [15:0] tlen_ff;
   reg  [15:0] up_ff;
   wire        off = ~|{high_side_on_o, low_side_on_o};
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tlen_ff <= 16'h0;
         up_ff   <= 16'h0;
      end else begin
         tlen_ff <= tach_o ? tlen_ff + 16'h1 : 16'h0;
         // Saturates so a long run never wraps back into the window
         up_ff   <= (&up_ff) ? up_ff : up_ff + 16'h1;
      end
   end
   // Held over depths 2 to 5 so any sync latency in that span passes
   sequence held(sig);
      $past(sig, 2) && $past(sig, 3) && $past(sig, 4) && $past(sig, 5);
   endsequence
   sequence slow_flip;
      !speed_above_thr_i && $changed(direction_i);
   endsequence
   chk_tach_width: assert property (
      $fell(tach_o) |-> tlen_ff == TACH_CYC) else $error("Tach width");
   chk_cross_cond: assert property (
      !(|(high_side_on_o & low_side_on_o))) else $error("Shoot-through");
   chk_brake_high: assert property (
      held(brake_below_thr_i) |-> high_side_on_o == 3'h0)
      else $error("High side on in brake");
   chk_coast_off: assert property (
      held(overvoltage_freewheel_input_i) |-> off) else $error("Coast");
   chk_fault_off: assert property (
      held(overcurrent_i) |-> off && softstart_discharge_o)
      else $error("Overcurrent not latched");
   chk_ss_release: assert property (
      $fell(softstart_discharge_o) |-> !$past(overcurrent_i, 4) &&
      $past(softstart_below_restart_i, 4)) else $error("Early restart");
   chk_dir_blank: assert property (
      slow_flip |-> ##[2:5] off) else $error("No blanking on reversal");
   chk_pwrup_hold: assert property (
      up_ff < PWRUP_CYC |-> high_side_on_o == 3'h0)
      else $error("High side on at power-up");
endmodule // bldc_checker
bind bldc_commutation_protection_logic bldc_checker #(
   .TACH_CYC(TACH_CYC), .PWRUP_CYC(PWRUP_CYC)) u_bldc_checker (.*);
`default_nettype wire

// ---- dv/hall_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hall_model (
   input  wire       ref_clk_i,
   input  wire       step_i,
   input  wire       bad_i,
   output wire [2:0] hall_o
);
   // 120 degree spacing: one bit flips per step, so no inversion needed
   localparam [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   reg [2:0] idx_ff = 3'h0;
   always @(posedge ref_clk_i) begin
      if (step_i) begin
         idx_ff <= (idx_ff == 3'h5) ? 3'h0 : idx_ff + 3'h1;
      end
   end
   assign hall_o = bad_i ? 3'h0 : SEQ[idx_ff * 3 +: 3];
endmodule // hall_model
`default_nettype wire

// ---- dv/test_bldc_commutation_protection_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_bldc_commutation_protection_logic;
   reg         ref_clk_i, reset_n_i, direction_i, speed_above_thr_i;
   reg         brake_below_thr_i, overvoltage_freewheel_input_i;
   reg         quad_select_i, pwm_trip_i, overcurrent_i, undervoltage_i;
   reg         softstart_below_restart_i, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, q, e;
   wire [31:0] prdata;
   wire        pready, pslverr, tach_o, softstart_discharge_o, irq_o;
   wire [2:0]  high_side_on_o, low_side_on_o, hall;
   wire        hall_sensor_one_i, hall_sensor_two_i, hall_sensor_three_i;
   wire [31:0] outs = {26'h0, high_side_on_o, low_side_on_o};
   reg         step, bad, perr;
   integer     seed, i, n_errors, checks, cyc;
   assign {hall_sensor_one_i, hall_sensor_two_i, hall_sensor_three_i} = hall;
   bldc_commutation_protection_logic #(.TACH_CYC(20), .PWRUP_CYC(30),
      .CHOP_DIV(8)) u_bldc_commutation_protection_logic (.*);
   hall_model u_hall_model (.ref_clk_i, .step_i(step), .bad_i(bad),
      .hall_o(hall));
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   task complete_run;
      begin
         if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         complete_run;
      end
   end
   task cmp(input [31:0] g, input [31:0] x);
      begin
         checks = checks + 1;
         if (g !== x) begin
            n_errors = n_errors + 1;
            $display("Error %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task step_hall;
      begin
         step <= 1'b1;
         tick(1);
         step <= 1'b0;
         tick(1);
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         tick(1);
         penable <= 1'b1;
         tick(1);
         while (pready !== 1'b1) tick(1);
         q = prdata;
         perr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         tick(1);
      end
   endtask
   function [31:0] dec(input [2:0] h, input d);
      reg [5:0] v;
      begin
         case (h)
            3'h1: v = 6'h0a;
            3'h3: v = 6'h0c;
            3'h2: v = 6'h14;
            3'h6: v = 6'h11;
            3'h4: v = 6'h21;
            3'h5: v = 6'h22;
            default: v = 6'h00;
         endcase
         dec = d ? {26'h0, v} : {26'h0, v[2:0], v[5:3]};
      end
   endfunction
   initial begin
      seed = 40;
      {n_errors, checks, cyc} = 0;
      {reset_n_i, direction_i, speed_above_thr_i, brake_below_thr_i} = 0;
      {overvoltage_freewheel_input_i, quad_select_i, pwm_trip_i} = 0;
      {overcurrent_i, undervoltage_i, psel, penable, pwrite} = 0;
      {step, bad, paddr, pwdata} = 0;
      softstart_below_restart_i = 1'b1;
      tick(4);
      reset_n_i <= 1'b1;
      tick(1);
      apb(1'b0, 12'h000, 32'h0);
      cmp(q, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      cmp({q[30:0], perr}, 32'h1);
      tick(60);
      cmp(softstart_discharge_o, 1'b0);
      // Speed stays low so every reversal is accepted
      for (i = 0; i < 10; i = i + 1) begin
         direction_i <= $random(seed);
         step_hall;
         tick(60);
         cmp(outs, dec(hall, direction_i));
      end
      step_hall;
      tick(4);
      e = dec(hall, direction_i);
      step_hall;
      tick(6);
      cmp(tach_o, 1'b1);
      cmp(outs, e);
      tick(40);
      cmp(outs, dec(hall, direction_i));
      apb(1'b1, 12'h00c, 32'h1f);
      cmp(irq_o, 1'b1);
      apb(1'b1, 12'h008, 32'h1f);
      apb(1'b0, 12'h008, 32'h0);
      cmp(q, 32'h0);
      cmp(irq_o, 1'b0);
      bad <= 1'b1;
      tick(40);
      cmp(outs, 32'h0);
      cmp(irq_o, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      cmp(q[4], 1'b1);
      apb(1'b1, 12'h00c, 32'h0);
      cmp(irq_o, 1'b0);
      bad <= 1'b0;
      brake_below_thr_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         {quad_select_i, pwm_trip_i} <= i;
         tick(10);
         cmp(outs, 32'h07);
      end
      {brake_below_thr_i, quad_select_i} <= 2'h0;
      tick(40);
      cmp(high_side_on_o, dec(hall, direction_i) >> 3);
      cmp(low_side_on_o, 32'h0);
      pwm_trip_i <= 1'b0;
      overvoltage_freewheel_input_i <= 1'b1;
      tick(10);
      cmp(outs, 32'h0);
      overvoltage_freewheel_input_i <= 1'b0;
      tick(20);
      e = outs;
      speed_above_thr_i <= 1'b1;
      tick(5);
      direction_i <= ~direction_i;
      tick(60);
      cmp(outs, e);
      speed_above_thr_i <= 1'b0;
      tick(60);
      for (i = 1; i < 3; i = i + 1) begin
         softstart_below_restart_i <= 1'b0;
         {undervoltage_i, overcurrent_i} <= i;
         tick(10);
         cmp(softstart_discharge_o, 1'b1);
         cmp(outs, 32'h0);
         {undervoltage_i, overcurrent_i} <= 2'h0;
         tick(10);
         cmp(softstart_discharge_o, 1'b1);
         softstart_below_restart_i <= 1'b1;
         tick(10);
         cmp(softstart_discharge_o, 1'b0);
      end
      complete_run;
   end
endmodule // test_bldc_commutation_protection_logic
`default_nettype wire
